/* File: core/ppo_pkg.sv */
/*
 * Package for the port output-type block: register map, field masks, reset
 * values, drive-type encoding and the pad control carrier.
 * Assumes a 32-bit AXI4-Lite register bus with an 8-bit byte address.
 */

// Behaviour
// [R01] each pin picks one of four drive types
// [R02] three 8-bit ports and one 2-bit port
// [R03] port 1 bit 5 always input-only, unconfigurable
// [R04] port 1 bits 2,3: input-only or open-drain only
// [R05] quasi: weak high, strong low
// [R06] quasi pin stays readable as an input
// [R07] open-drain: no pull-up, pull-down on zero
// [R08] outside party supplies open-drain pull-up
// [R09] input-only: both drivers off
// [R10] push-pull: strong high and strong low
// [R11] software sets analog pins to input-only
// [R12] port 0 bits 1-5 digital input disable
// [R13] reset clears port 0 input disable bits
// [R14] power-up leaves every pin input-only
// [R15] unique two-bit codes, reset code is input-only

package ppo_pkg;

   localparam int NUM_PORTS = 4;
   localparam int PORT_W = 8;
   localparam int AXI_ADDR_W = 8;

   // ******************************************************************
   // register map
   // ******************************************************************
   localparam logic [7:0] OFS_PORT_STRIDE = 8'h10;
   localparam logic [1:0] FLD_LATCH = 2'h0;
   localparam logic [1:0] FLD_CFG_A = 2'h1;
   localparam logic [1:0] FLD_CFG_B = 2'h2;
   localparam logic [1:0] FLD_PIN = 2'h3;
   localparam logic [7:0] OFS_DIN_DISABLE = 8'h40;

   // ******************************************************************
   // field masks and reset values
   // ******************************************************************
   localparam logic [7:0] WIDE_PORT_MASK = 8'hFF;
   localparam logic [7:0] NARROW_PORT_MASK = 8'h03;
   localparam int NARROW_PORT = 3;
   localparam int SHARED_PORT = 1;
   localparam int RESET_PIN_BIT = 5;
   localparam logic [7:0] RESTRICTED_BITS = 8'h0C;
   localparam logic [7:0] DIN_DISABLE_MASK = 8'h3E;
   localparam logic [7:0] LATCH_RST = 8'hFF;
   localparam logic [7:0] CFG_RST = 8'h00;
   localparam logic [7:0] DIN_DISABLE_RST = 8'h00;

   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // code = {cfg_a bit, cfg_b bit}; all-zero reset code is input-only
   typedef enum logic [1:0] {
      drive_input_only,
      drive_quasi,
      drive_push_pull,
      drive_open_drain
   } ppo_drive_e;

   typedef struct packed {
      logic [7:0] drive_val;
      logic [7:0] drive_en;
      logic [7:0] weak_up;
   } ppo_pad_s;

   function automatic logic [7:0] port_mask(input int p);
      return (p == NARROW_PORT) ? NARROW_PORT_MASK : WIDE_PORT_MASK;
   endfunction

endpackage

/* File: core/ppo_port_config.sv */
/*
 * Per-pin drive-type control for four general-purpose ports, with input
 * synchronisers, port 0 digital input disable and an AXI4-Lite slave.
 * Assumes pads resolve drive_en/drive_val/weak_up into the real pin and
 * return the pin level on pad_in, asynchronous to aclk.
 */
// The implementer's own choices: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps

module ppo_port_config (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [3:0][7:0] pad_in,
   output ppo_pkg::ppo_pad_s [3:0] pad_ctl,
   output logic [3:0][7:0] pin_level
);

   // ******************************************************************
   // storage
   // ******************************************************************
   logic [3:0][7:0] latch;
   logic [3:0][7:0] cfg_a;
   logic [3:0][7:0] cfg_b;
   logic [7:0] din_disable;
   logic [3:0][7:0] sync1;
   logic [3:0][7:0] sync2;
   logic [3:0][7:0] sync3;
   logic [3:0][7:0] filt;

   wire [3:0][7:0] next_val;
   wire [3:0][7:0] next_en;
   wire [3:0][7:0] next_weak;
   wire [3:0][7:0] is_quasi;
   wire [3:0][7:0] is_pp;
   wire [3:0][7:0] is_od;
   wire [3:0][7:0] is_in;

   logic wr_go;
   logic rd_go;

   // ******************************************************************
   // decoding
   // ******************************************************************
   function automatic logic addr_hit(input logic [7:0] addr);
      return (addr[1:0] == 2'h0) && ((addr[7:6] == 2'h0) || (addr == ppo_pkg::OFS_DIN_DISABLE));
   endfunction

   function automatic logic is_port_reg(input logic [7:0] addr);
      return addr[7:6] == 2'h0;
   endfunction

   // bits that a cfg write may store; the shared reset pin never takes one
   function automatic logic [7:0] cfg_store_mask(input int p);
      logic [7:0] m;
      m = ppo_pkg::port_mask(p);
      if (p == ppo_pkg::SHARED_PORT) begin
         m[ppo_pkg::RESET_PIN_BIT] = 1'b0; // [R03]
      end
      return m;
   endfunction

   // restricted pins fall back to input-only for codes they may not take
   function automatic ppo_pkg::ppo_drive_e eff_mode(input int p, input int b, input logic a, input logic c);
      ppo_pkg::ppo_drive_e m;
      logic [7:0] pm;
      m = ppo_pkg::ppo_drive_e'({a, c}); // [R15]
      pm = ppo_pkg::port_mask(p);
      if (!pm[b]) begin
         m = ppo_pkg::drive_input_only; // [R02]
      end else if (p == ppo_pkg::SHARED_PORT && b == ppo_pkg::RESET_PIN_BIT) begin
         m = ppo_pkg::drive_input_only; // [R03]
      end else if (p == ppo_pkg::SHARED_PORT && ppo_pkg::RESTRICTED_BITS[b] &&
                   (m == ppo_pkg::drive_quasi || m == ppo_pkg::drive_push_pull)) begin
         m = ppo_pkg::drive_input_only; // [R04]
      end
      return m;
   endfunction

   // {drive_val, drive_en, weak_up} for one pin
   function automatic logic [2:0] pin_drive(input ppo_pkg::ppo_drive_e m, input logic l);
      unique case (m)
         ppo_pkg::drive_input_only: return 3'h0; // [R09]
         ppo_pkg::drive_quasi: return {1'b0, ~l, l}; // [R05]
         ppo_pkg::drive_push_pull: return {l, 1'b1, 1'b0}; // [R10]
         ppo_pkg::drive_open_drain: return {1'b0, ~l, 1'b0}; // [R07]
      endcase
   endfunction

   // ******************************************************************
   // per-pin drive generation
   // ******************************************************************
   for (genvar p = 0; p < ppo_pkg::NUM_PORTS; p++) begin : g_port
      for (genvar b = 0; b < ppo_pkg::PORT_W; b++) begin : g_bit
         ppo_pkg::ppo_drive_e mode;
         logic [2:0] drv;
         assign mode = eff_mode(p, b, cfg_a[p][b], cfg_b[p][b]); // [R01]
         assign drv = pin_drive(mode, latch[p][b]);
         assign next_val[p][b] = drv[2];
         assign next_en[p][b] = drv[1];
         assign next_weak[p][b] = drv[0];
         assign is_in[p][b] = mode == ppo_pkg::drive_input_only;
         assign is_quasi[p][b] = mode == ppo_pkg::drive_quasi;
         assign is_pp[p][b] = mode == ppo_pkg::drive_push_pull;
         assign is_od[p][b] = mode == ppo_pkg::drive_open_drain;
      end
   end

   always_ff @(posedge aclk) begin
      for (int p = 0; p < ppo_pkg::NUM_PORTS; p++) begin
         if (!aresetn) begin
            pad_ctl[p] <= '0; // [R14]
         end else begin
            pad_ctl[p].drive_val <= next_val[p];
            pad_ctl[p].drive_en <= next_en[p];
            pad_ctl[p].weak_up <= next_weak[p];
         end
      end
   end

   // ******************************************************************
   // pin input path
   // ******************************************************************
   // three stages; a level counts only once stages two and three agree
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sync1 <= '0;
         sync2 <= '0;
         sync3 <= '0;
         filt <= '0;
      end else begin
         sync1 <= pad_in;
         sync2 <= sync1;
         sync3 <= sync2;
         for (int p = 0; p < ppo_pkg::NUM_PORTS; p++) begin
            for (int b = 0; b < ppo_pkg::PORT_W; b++) begin
               if (sync2[p][b] == sync3[p][b]) begin
                  filt[p][b] <= sync3[p][b];
               end
            end
         end
      end
   end

   // input is read whatever the drive type, so quasi pins double as inputs
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pin_level <= '0;
      end else begin
         for (int p = 0; p < ppo_pkg::NUM_PORTS; p++) begin
            pin_level[p] <= filt[p] & ppo_pkg::port_mask(p); // [R06]
         end
         pin_level[0] <= filt[0] & ~din_disable; // [R12]
      end
   end

   // ******************************************************************
   // register writes
   // ******************************************************************
   // address and data are taken together, so no skid storage is needed
   assign wr_go = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
   assign s_axi_awready = wr_go;
   assign s_axi_wready = wr_go;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         // absent port 3 bits reset to zero, so they read back as zero
         for (int p = 0; p < ppo_pkg::NUM_PORTS; p++) begin
            latch[p] <= ppo_pkg::LATCH_RST & ppo_pkg::port_mask(p);
         end
         cfg_a <= {4{ppo_pkg::CFG_RST}}; // [R14]
         cfg_b <= {4{ppo_pkg::CFG_RST}};
      end else if (wr_go && s_axi_wstrb[0] && is_port_reg(s_axi_awaddr) && addr_hit(s_axi_awaddr)) begin
         for (int p = 0; p < ppo_pkg::NUM_PORTS; p++) begin
            if (s_axi_awaddr[5:4] == 2'(p)) begin
               unique case (s_axi_awaddr[3:2])
                  ppo_pkg::FLD_LATCH: latch[p] <= s_axi_wdata[7:0] & ppo_pkg::port_mask(p);
                  ppo_pkg::FLD_CFG_A: cfg_a[p] <= s_axi_wdata[7:0] & cfg_store_mask(p); // [R01]
                  ppo_pkg::FLD_CFG_B: cfg_b[p] <= s_axi_wdata[7:0] & cfg_store_mask(p);
                  ppo_pkg::FLD_PIN: ;
               endcase
            end
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         din_disable <= ppo_pkg::DIN_DISABLE_RST; // [R13]
      end else if (wr_go && s_axi_wstrb[0] && s_axi_awaddr == ppo_pkg::OFS_DIN_DISABLE) begin
         din_disable <= s_axi_wdata[7:0] & ppo_pkg::DIN_DISABLE_MASK; // [R12]
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= ppo_pkg::RESP_OKAY;
      end else if (wr_go) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= addr_hit(s_axi_awaddr) ? ppo_pkg::RESP_OKAY : ppo_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // ******************************************************************
   // register reads
   // ******************************************************************
   assign s_axi_arready = !s_axi_rvalid;
   assign rd_go = s_axi_arvalid && s_axi_arready;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= ppo_pkg::RESP_OKAY;
      end else if (rd_go) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= '0;
         s_axi_rresp <= addr_hit(s_axi_araddr) ? ppo_pkg::RESP_OKAY : ppo_pkg::RESP_SLVERR;
         if (s_axi_araddr == ppo_pkg::OFS_DIN_DISABLE) begin
            s_axi_rdata[7:0] <= din_disable;
         end else if (addr_hit(s_axi_araddr)) begin
            unique case (s_axi_araddr[3:2])
               ppo_pkg::FLD_LATCH: s_axi_rdata[7:0] <= latch[s_axi_araddr[5:4]];
               ppo_pkg::FLD_CFG_A: s_axi_rdata[7:0] <= cfg_a[s_axi_araddr[5:4]];
               ppo_pkg::FLD_CFG_B: s_axi_rdata[7:0] <= cfg_b[s_axi_araddr[5:4]];
               ppo_pkg::FLD_PIN: s_axi_rdata[7:0] <= pin_level[s_axi_araddr[5:4]]; // [R06]
            endcase
         end
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // ******************************************************************
   // checks
   // ******************************************************************
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence seq_cfg_a_write0;
      wr_go && s_axi_wstrb[0] && s_axi_awaddr == ppo_pkg::OFS_PORT_STRIDE * 8'h00 + 8'h04;
   endsequence

   sequence seq_resp_out;
      s_axi_bvalid && s_axi_bresp == ppo_pkg::RESP_OKAY;
   endsequence

   chk_cfg_update: assert property (seq_cfg_a_write0 |=> seq_resp_out ##0 cfg_a[0] == $past(s_axi_wdata[7:0])) // [R01]
      else $error("cfg write to port 0 not stored");

   chk_narrow_port: assert property (pad_ctl[3].drive_en[7:2] == 6'h00 && pad_ctl[3].weak_up[7:2] == 6'h00) // [R02]
      else $error("absent port 3 bits driven");

   chk_reset_pin: assert property (!pad_ctl[1].drive_en[5] && !pad_ctl[1].weak_up[5] && cfg_a[1][5] == 1'b0) // [R03]
      else $error("shared reset pin driven or configured");

   chk_restricted_high: assert property ((pad_ctl[1].weak_up & ppo_pkg::RESTRICTED_BITS) == 8'h00 &&
                                         (pad_ctl[1].drive_val & ppo_pkg::RESTRICTED_BITS) == 8'h00) // [R04]
      else $error("restricted pin driven high");

   chk_quasi_drive: assert property (is_quasi[0][0] |=> pad_ctl[0].weak_up[0] == $past(latch[0][0]) &&
                                     pad_ctl[0].drive_en[0] == !$past(latch[0][0])) // [R05]
      else $error("quasi drive wrong");

   chk_pin_read: assert property (##3 pin_level[2] == $past(filt[2])) // [R06]
      else $error("pin level not following input");

   chk_open_drain: assert property (is_od[0][1] |=> !pad_ctl[0].weak_up[1] && !pad_ctl[0].drive_val[1] &&
                                    pad_ctl[0].drive_en[1] == !$past(latch[0][1])) // [R07]
      else $error("open drain drive wrong");

   chk_input_only: assert property (is_in[2][4] |=> !pad_ctl[2].drive_en[4] && !pad_ctl[2].weak_up[4]) // [R09]
      else $error("input-only pin driven");

   chk_push_pull: assert property (is_pp[0][2] |=> pad_ctl[0].drive_en[2] &&
                                   pad_ctl[0].drive_val[2] == $past(latch[0][2])) // [R10]
      else $error("push-pull drive wrong");

   chk_din_block: assert property (din_disable[3] |=> !pin_level[0][3]) // [R12]
      else $error("disabled input reaches pin level");

   chk_after_reset: assert property (!$past(aresetn) |-> din_disable == 8'h00 && pad_ctl[0].drive_en == 8'h00 &&
                                     pad_ctl[1].weak_up == 8'h00) // [R13] [R14]
      else $error("state after reset wrong");

   chk_reset_cfg: assert property (!$past(aresetn) |-> cfg_a == '0 && cfg_b == '0 && // [R14] [R15]
                                   pad_ctl[2].drive_en == 8'h00 && pad_ctl[3].drive_en == 8'h00)
      else $error("configuration after reset not input-only");

   chk_narrow_level: assert property (pin_level[3][7:2] == 6'h00 && latch[3][7:2] == 6'h00) // [R02]
      else $error("absent port 3 bits hold a level");

   chk_restricted_in: assert property (cfg_a[1][2] != cfg_b[1][2] |=> // [R04]
                                       !pad_ctl[1].drive_en[2] && !pad_ctl[1].weak_up[2])
      else $error("restricted pin took quasi or push-pull");

   chk_restricted_od: assert property (is_od[1][3] |=> pad_ctl[1].drive_en[3] == !$past(latch[1][3])) // [R04]
      else $error("restricted pin open drain wrong");

   chk_din_pass: assert property (!din_disable[2] |=> pin_level[0][2] == $past(filt[0][2])) // [R12]
      else $error("enabled input blocked");

   chk_din_mask: assert property ((din_disable & ~ppo_pkg::DIN_DISABLE_MASK) == 8'h00) // [R12]
      else $error("input disable bit outside 1 to 5 set");

   sequence seq_pin_read_p2;
      rd_go && s_axi_araddr == {2'h0, 2'h2, ppo_pkg::FLD_PIN, 2'h0};
   endsequence

   sequence seq_read_out;
      s_axi_rvalid && s_axi_rresp == ppo_pkg::RESP_OKAY && s_axi_rdata[31:8] == 24'h00_0000;
   endsequence

   chk_pin_reg_read: assert property (seq_pin_read_p2 |=> // [R06]
                                      seq_read_out ##0 s_axi_rdata[7:0] == $past(pin_level[2]))
      else $error("pin register read wrong");

   // every pin, not only the sampled ones above
   for (genvar p = 0; p < ppo_pkg::NUM_PORTS; p++) begin : g_chk_port
      for (genvar b = 0; b < ppo_pkg::PORT_W; b++) begin : g_chk_bit
         chk_any_input: assert property (@(posedge aclk) disable iff (!aresetn) is_in[p][b] |=> // [R09]
                                         !pad_ctl[p].drive_en[b] && !pad_ctl[p].weak_up[b])
            else $error("input-only pin driven");

         chk_any_open_drain: assert property (@(posedge aclk) disable iff (!aresetn) is_od[p][b] |=> // [R07]
                                              !pad_ctl[p].weak_up[b] && !pad_ctl[p].drive_val[b])
            else $error("open-drain pin pulled up");
      end
   end

endmodule

/* File: testbench/port_pin_output_config_bench.sv */
/*
 * Self-checking bench: AXI4-Lite master, register and pad model, random
 * configuration of every port, unmapped access and a reset in mid-run.
 * Assumes the pad partner resolves pins with board pull-ups.
 */
`timescale 1ns/1ps

module port_pin_output_config_bench;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [7:0] s_axi_awaddr = 8'h00;
   logic s_axi_awvalid = 1'b0;
   logic s_axi_awready;
   logic [31:0] s_axi_wdata = 32'h0000_0000;
   logic [3:0] s_axi_wstrb = 4'h0;
   logic s_axi_wvalid = 1'b0;
   logic s_axi_wready;
   logic [1:0] s_axi_bresp;
   logic s_axi_bvalid;
   logic s_axi_bready = 1'b0;
   logic [7:0] s_axi_araddr = 8'h00;
   logic s_axi_arvalid = 1'b0;
   logic s_axi_arready;
   logic [31:0] s_axi_rdata;
   logic [1:0] s_axi_rresp;
   logic s_axi_rvalid;
   logic s_axi_rready = 1'b0;
   logic [3:0][7:0] pad_in;
   ppo_pkg::ppo_pad_s [3:0] pad_ctl;
   logic [3:0][7:0] pin_level;
   logic [3:0][7:0] ext_en = '0;
   logic [3:0][7:0] ext_val = '0;
   logic [7:0] m_lat[4];
   logic [7:0] m_ca[4];
   logic [7:0] m_cb[4];
   logic [7:0] m_dis;
   logic [31:0] lfsr = 32'h7fd5_1804;
   int bad_count = 0;
   int cmp_count = 0;

   always #50 aclk = ~aclk;

   ppo_port_config u_ppo_port_config (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .pad_in(pad_in),
      .pad_ctl(pad_ctl), .pin_level(pin_level));

   ppo_pad_partner u_ppo_pad_partner (.pad_ctl(pad_ctl), .ext_en(ext_en), .ext_val(ext_val),
      .pad_in(pad_in));

   // ************************************************************
   // model
   // ************************************************************
   function automatic logic [31:0] rnd();
      lfsr = {lfsr[30:0], ^(lfsr & 32'h8020_0003)};
      return lfsr;
   endfunction

   function automatic logic [7:0] pmask(input int p);
      return (p == 3) ? 8'h03 : 8'hFF;
   endfunction

   function automatic ppo_pkg::ppo_pad_s exp_pad(input int p);
      ppo_pkg::ppo_pad_s s;
      logic [1:0] c;
      s = '0;
      for (int b = 0; b < 8; b++) begin
         c = {m_ca[p][b], m_cb[p][b]};
         if (p == 1 && (b == 2 || b == 3) && c != 2'b11) c = 2'b00;
         case (c)
            2'b01: begin
               s.weak_up[b] = m_lat[p][b];
               s.drive_en[b] = !m_lat[p][b];
            end
            2'b10: begin
               s.drive_en[b] = 1'b1;
               s.drive_val[b] = m_lat[p][b];
            end
            2'b11: s.drive_en[b] = !m_lat[p][b];
            default: ;
         endcase
      end
      return s;
   endfunction

   task automatic model_reset();
      for (int p = 0; p < 4; p++) begin
         m_lat[p] = pmask(p);
         m_ca[p] = 8'h00;
         m_cb[p] = 8'h00;
      end
      m_dis = 8'h00;
   endtask

   // ************************************************************
   // bus and checks
   // ************************************************************
   task automatic cmp_data(input string what, input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (got !== exp) begin
         bad_count++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic cmp_resp(input string what, input logic [1:0] exp, input logic [1:0] got);
      cmp_data(what, {30'h0, exp}, {30'h0, got});
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] st, input logic [1:0] er);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= st;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do @(posedge aclk); while (s_axi_awready !== 1'b1);
      s_axi_awvalid <= 1'b0;
      s_axi_wvalid <= 1'b0;
      while (s_axi_bvalid !== 1'b1) @(posedge aclk);
      s_axi_bready <= 1'b0;
      cmp_resp("bresp", er, s_axi_bresp);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(posedge aclk); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      while (s_axi_rvalid !== 1'b1) @(posedge aclk);
      s_axi_rready <= 1'b0;
      cmp_resp("rresp", er, s_axi_rresp);
      if (er == 2'b00) cmp_data("rdata", exp, s_axi_rdata);
   endtask

   task automatic check_all();
      ppo_pkg::ppo_pad_s s;
      logic [7:0] lv;
      repeat (8) @(posedge aclk);
      for (int p = 0; p < 4; p++) begin
         s = exp_pad(p);
         lv = ((s.drive_en & s.drive_val) | (~s.drive_en & ~(ext_en[p] & ~ext_val[p]))) & pmask(p);
         if (p == 0) lv = lv & ~m_dis;
         cmp_data("drive_en", {24'h0, s.drive_en}, {24'h0, pad_ctl[p].drive_en});
         cmp_data("weak_up", {24'h0, s.weak_up}, {24'h0, pad_ctl[p].weak_up});
         cmp_data("drive_val", {24'h0, s.drive_val}, {24'h0, pad_ctl[p].drive_val});
         cmp_data("pin_level", {24'h0, lv}, {24'h0, pin_level[p]});
         rd(8'(p * 16), {24'h0, m_lat[p]}, 2'b00);
         rd(8'(p * 16 + 4), {24'h0, m_ca[p]}, 2'b00);
         rd(8'(p * 16 + 8), {24'h0, m_cb[p]}, 2'b00);
         rd(8'(p * 16 + 12), {24'h0, lv}, 2'b00);
      end
      rd(8'h40, {24'h0, m_dis}, 2'b00);
   endtask

   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask

   // ************************************************************
   // scenarios
   // ************************************************************
   initial begin
      repeat (20000) @(posedge aclk);
      bad_count++;
      report_and_stop();
   end

   initial begin
      logic [31:0] r;
      int p;
      model_reset();
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      check_all();
      for (int i = 0; i < 40; i++) begin
         r = rnd();
         p = int'(r[1:0]);
         wr(8'(p * 16), rnd(), 4'h1, 2'b00);
         m_lat[p] = lfsr[7:0] & pmask(p);
         wr(8'(p * 16 + 4), rnd(), 4'h1, 2'b00);
         m_ca[p] = lfsr[7:0] & pmask(p) & ((p == 1) ? 8'hDF : 8'hFF);
         wr(8'(p * 16 + 8), rnd(), 4'h1, 2'b00);
         m_cb[p] = lfsr[7:0] & pmask(p) & ((p == 1) ? 8'hDF : 8'hFF);
         wr(8'(p * 16 + 12), rnd(), 4'h1, 2'b00);
         wr(8'h40, rnd(), 4'h1, 2'b00);
         m_dis = lfsr[7:0] & 8'h3E;
         wr(8'(p * 16), rnd(), 4'h0, 2'b00);
         @(posedge aclk);
         ext_en <= rnd();
         ext_val <= '0;
         check_all();
      end
      // analog use of port 0 bits 1-5: drivers off and digital inputs blocked
      wr(8'h04, {24'h0, m_ca[0] & 8'hC1}, 4'h1, 2'b00);
      m_ca[0] = m_ca[0] & 8'hC1;
      wr(8'h08, {24'h0, m_cb[0] & 8'hC1}, 4'h1, 2'b00);
      m_cb[0] = m_cb[0] & 8'hC1;
      wr(8'h40, 32'h0000_003E, 4'h1, 2'b00);
      m_dis = 8'h3E;
      check_all();
      wr(8'h50, 32'h0000_00FF, 4'h1, 2'b10);
      rd(8'h50, 32'h0000_0000, 2'b10);
      @(posedge aclk);
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      model_reset();
      check_all();
      report_and_stop();
   end
endmodule

/* File: testbench/ppo_pad_partner.sv */
/*
 * Board-side model of the port pins: resolves pad control against board
 * pull-ups and an outside driver that can only pull pins low.
 * Assumes every pin carries a board pull-up resistor.
 */
`timescale 1ns/1ps

module ppo_pad_partner (
   input wire ppo_pkg::ppo_pad_s [3:0] pad_ctl,
   input wire logic [3:0][7:0] ext_en,
   input wire logic [3:0][7:0] ext_val,
   output logic [3:0][7:0] pad_in
);
   always_comb begin
      for (int p = 0; p < 4; p++) begin
         // strong drive wins; weak pull-up or board resistor reads high unless pulled low
         pad_in[p] = (pad_ctl[p].drive_en & pad_ctl[p].drive_val)
            | (~pad_ctl[p].drive_en & ~(ext_en[p] & ~ext_val[p]));
      end
   end
endmodule
